// ===== include/gpcfg_map.svh
`ifndef GPCFG_MAP_SVH
`define GPCFG_MAP_SVH

`define GPCFG_OFS_MODE     8'h00
`define GPCFG_OFS_TYPE     8'h04
`define GPCFG_OFS_SLEW     8'h08
`define GPCFG_OFS_PULL     8'h0C
`define GPCFG_OFS_LEVEL    8'h10

`define GPCFG_RST_MODE     32'hFFFAFFFF
`define GPCFG_RST_TYPE     32'h00000000
`define GPCFG_RST_SLEW     32'h0000FFFF
`define GPCFG_RST_PULL     32'h00090000
`define GPCFG_RST_LEVEL    16'h0000

`define GPCFG_MAX_PINS     16
`define GPCFG_FIELD_W      2

`define GPCFG_RESP_OKAY    2'h0
`define GPCFG_RESP_SLVERR  2'h2

`endif

// ===== include/gpcfg_pkg.sv
package gpcfg_pkg;

	typedef enum logic [1:0] {
		GPCFG_MODE_INPUT  = 2'h0,
		GPCFG_MODE_OUTPUT = 2'h1,
		GPCFG_MODE_ALT    = 2'h2,
		GPCFG_MODE_ANALOG = 2'h3
	} gpcfg_mode_t;

	typedef enum logic [1:0] {
		GPCFG_PULL_NONE = 2'h0,
		GPCFG_PULL_UP   = 2'h1,
		GPCFG_PULL_DOWN = 2'h2,
		GPCFG_PULL_RSVD = 2'h3
	} gpcfg_pull_t;

endpackage

// ===== include/gpcfg_regbus_if.sv
`timescale 1ns/10ps

interface gpcfg_regbus_if #(
	parameter int ADDR_W = 8
);
	logic              wrStb;
	logic [ADDR_W-1:0] wrAddr;
	logic [31:0]       wrData;
	logic [3:0]        wrStrb;
	logic              wrHit;
	logic [ADDR_W-1:0] rdAddr;
	logic [31:0]       rdData;
	logic              rdHit;

	modport slave_end (
		output wrStb, wrAddr, wrData, wrStrb, rdAddr,
		input  wrHit, rdData, rdHit
	);

	modport reg_end (
		input  wrStb, wrAddr, wrData, wrStrb, rdAddr,
		output wrHit, rdData, rdHit
	);
endinterface

// ===== verilog/gpcfg_axil_slave.sv
`timescale 1ns/10ps
`include "gpcfg_map.svh"

module gpcfg_axil_slave #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              reset,
	// Write channels.
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// Read channels.
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Register side.
	gpcfg_regbus_if.slave_end      bus
);
	logic              awHeld_q;
	logic              wHeld_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	logic              bValid_q;
	logic [1:0]        bResp_q;
	logic              rValid_q;
	logic [1:0]        rResp_q;
	logic [31:0]       rData_q;
	wire               awTake;
	wire               wTake;
	wire               arTake;
	wire               doWrite;

	assign s_axi_awready = !awHeld_q && !bValid_q;
	assign s_axi_wready  = !wHeld_q && !bValid_q;
	assign s_axi_arready = !rValid_q;
	assign awTake        = s_axi_awvalid && s_axi_awready;
	assign wTake         = s_axi_wvalid && s_axi_wready;
	assign arTake        = s_axi_arvalid && s_axi_arready;
	assign doWrite       = awHeld_q && wHeld_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rresp   = rResp_q;
	assign s_axi_rdata   = rData_q;
	assign bus.wrStb     = doWrite;
	assign bus.wrAddr    = awAddr_q;
	assign bus.wrData    = wData_q;
	assign bus.wrStrb    = wStrb_q;
	assign bus.rdAddr    = s_axi_araddr;

	// Address and data are caught in either order; the write fires once both are held.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= '0;
			wData_q  <= 32'h00000000;
			wStrb_q  <= 4'h0;
			bValid_q <= 1'b0;
			bResp_q  <= `GPCFG_RESP_OKAY;
		end
		else
		begin
			if (awTake)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (wTake)
			begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
				bValid_q <= 1'b1;
				bResp_q  <= bus.wrHit ? `GPCFG_RESP_OKAY : `GPCFG_RESP_SLVERR;
			end
			else if (bValid_q && s_axi_bready)
				bValid_q <= 1'b0;
		end
	end

	// Read data is captured on the address handshake.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			rValid_q <= 1'b0;
			rResp_q  <= `GPCFG_RESP_OKAY;
			rData_q  <= 32'h00000000;
		end
		else if (arTake)
		begin
			rValid_q <= 1'b1;
			rResp_q  <= bus.rdHit ? `GPCFG_RESP_OKAY : `GPCFG_RESP_SLVERR;
			rData_q  <= bus.rdData;
		end
		else if (rValid_q && s_axi_rready)
			rValid_q <= 1'b0;
	end
endmodule

// ===== verilog/gpcfg_port.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "gpcfg_map.svh"

module gpcfg_port #(
	parameter int PIN_COUNT = 16,
	parameter int ADDR_W    = 8
) (
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              reset,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Pad levels.
	input  wire logic [15:0]       padIn,
	// Raw pad configuration.
	output logic [31:0]            pinMode,
	output logic [15:0]            driverType,
	output logic [15:0]            edgeRate,
	output logic [31:0]            pullSelect,
	// Decoded pad controls.
	output logic [15:0]            padAnalog,
	output logic [15:0]            padDigitalOut,
	output logic [15:0]            padAltFunc,
	output logic [15:0]            padOpenDrain,
	output logic [15:0]            padPullUp,
	output logic [15:0]            padPullDown
);
	function automatic logic [31:0] spreadBits(input logic [15:0] b);
		logic [31:0] r;
		r = 32'h00000000;
		for (int i = 0; i < 16; i++)
		begin
			r[2*i]   = b[i];
			r[2*i+1] = b[i];
		end
		return r;
	endfunction

	function automatic logic [31:0] laneMask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic [31:0] mergeWrite(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb,
		input logic [31:0] keep
	);
		logic [31:0] lanes;
		lanes = laneMask(strb);
		return ((old & ~lanes) | (data & lanes)) & keep;
	endfunction

	function automatic logic [15:0] fieldIs(input logic [31:0] f, input logic [1:0] code);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++)
			r[i] = (f[2*i +: 2] == code);
		return r;
	endfunction

	function automatic logic addrIs(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		return {a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs);
	endfunction

	localparam logic [15:0] PIN_MASK   = 16'((32'h1 << PIN_COUNT) - 32'h1);
	localparam logic [31:0] BIT_MASK   = {16'h0000, PIN_MASK};
	localparam logic [31:0] FIELD_MASK = spreadBits(PIN_MASK);
	localparam logic [31:0] RST_MODE   = `GPCFG_RST_MODE & FIELD_MASK;
	localparam logic [31:0] RST_TYPE   = `GPCFG_RST_TYPE & BIT_MASK;
	localparam logic [31:0] RST_SLEW   = `GPCFG_RST_SLEW & BIT_MASK;
	localparam logic [31:0] RST_PULL   = `GPCFG_RST_PULL & FIELD_MASK;

	if (PIN_COUNT < 1 || PIN_COUNT > `GPCFG_MAX_PINS)
		$error("PIN_COUNT must lie between 1 and 16.");
	if (ADDR_W < 5 || ADDR_W > 32)
		$error("ADDR_W must lie between 5 and 32.");

	gpcfg_regbus_if #(.ADDR_W(ADDR_W)) bus ();

	gpcfg_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
		.clock         (clock),
		.reset         (reset),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.bus           (bus.slave_end)
	);

	logic [31:0] modeQ;
	logic [31:0] typeQ;
	logic [31:0] slewQ;
	logic [31:0] pullQ;
	logic [15:0] syncMeta_q;
	logic [15:0] levelQ;
	logic [15:0] analog_q;
	logic [15:0] digOut_q;
	logic [15:0] altFunc_q;
	logic [15:0] openDrain_q;
	logic [15:0] pullUp_q;
	logic [15:0] pullDown_q;
	wire  [31:0] modeD;
	wire  [31:0] typeD;
	wire  [31:0] slewD;
	wire  [31:0] pullD;
	wire  [15:0] digOutD;
	wire         modeWr;
	wire         typeWr;
	wire         slewWr;
	wire         pullWr;
	wire         levelWr;
	wire         rdMode;
	wire         rdType;
	wire         rdSlew;
	wire         rdPull;
	wire         rdLevel;
	wire  [31:0] rdWord;

	assign modeWr  = bus.wrStb && addrIs(bus.wrAddr, `GPCFG_OFS_MODE);
	assign typeWr  = bus.wrStb && addrIs(bus.wrAddr, `GPCFG_OFS_TYPE);
	assign slewWr  = bus.wrStb && addrIs(bus.wrAddr, `GPCFG_OFS_SLEW);
	assign pullWr  = bus.wrStb && addrIs(bus.wrAddr, `GPCFG_OFS_PULL);
	assign levelWr = bus.wrStb && addrIs(bus.wrAddr, `GPCFG_OFS_LEVEL);
	assign bus.wrHit = addrIs(bus.wrAddr, `GPCFG_OFS_MODE) ||
		addrIs(bus.wrAddr, `GPCFG_OFS_TYPE) || addrIs(bus.wrAddr, `GPCFG_OFS_SLEW) ||
		addrIs(bus.wrAddr, `GPCFG_OFS_PULL) || addrIs(bus.wrAddr, `GPCFG_OFS_LEVEL);

	// mode fields merge by byte lane
	assign modeD = modeWr ? mergeWrite(modeQ, bus.wrData, bus.wrStrb, FIELD_MASK) : modeQ;
	assign typeD = typeWr ? mergeWrite(typeQ, bus.wrData, bus.wrStrb, BIT_MASK) : typeQ;
	assign slewD = slewWr ? mergeWrite(slewQ, bus.wrData, bus.wrStrb, BIT_MASK) : slewQ;
	// pull fields merge by byte lane
	assign pullD = pullWr ? mergeWrite(pullQ, bus.wrData, bus.wrStrb, FIELD_MASK) : pullQ;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			modeQ <= RST_MODE;
			typeQ <= RST_TYPE;
			slewQ <= RST_SLEW;
			pullQ <= RST_PULL;
		end
		else
		begin
			modeQ <= modeD;
			typeQ <= typeD;
			slewQ <= slewD;
			pullQ <= pullD;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			syncMeta_q <= `GPCFG_RST_LEVEL;
			levelQ     <= `GPCFG_RST_LEVEL;
		end
		else
		begin
			syncMeta_q <= padIn & PIN_MASK;
			levelQ     <= syncMeta_q;
		end
	end

	// reserved pull code drives neither resistor
	assign digOutD = fieldIs(modeD, gpcfg_pkg::GPCFG_MODE_OUTPUT) |
		fieldIs(modeD, gpcfg_pkg::GPCFG_MODE_ALT);

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			analog_q    <= fieldIs(RST_MODE, gpcfg_pkg::GPCFG_MODE_ANALOG);
			digOut_q    <= fieldIs(RST_MODE, gpcfg_pkg::GPCFG_MODE_OUTPUT) |
				fieldIs(RST_MODE, gpcfg_pkg::GPCFG_MODE_ALT);
			altFunc_q   <= fieldIs(RST_MODE, gpcfg_pkg::GPCFG_MODE_ALT);
			openDrain_q <= 16'h0000;
			pullUp_q    <= fieldIs(RST_PULL, gpcfg_pkg::GPCFG_PULL_UP);
			pullDown_q  <= fieldIs(RST_PULL, gpcfg_pkg::GPCFG_PULL_DOWN);
		end
		else
		begin
			analog_q    <= fieldIs(modeD, gpcfg_pkg::GPCFG_MODE_ANALOG);
			digOut_q    <= digOutD;
			altFunc_q   <= fieldIs(modeD, gpcfg_pkg::GPCFG_MODE_ALT);
			openDrain_q <= typeD[15:0] & digOutD;
			pullUp_q    <= fieldIs(pullD, gpcfg_pkg::GPCFG_PULL_UP);
			pullDown_q  <= fieldIs(pullD, gpcfg_pkg::GPCFG_PULL_DOWN);
		end
	end

	assign pinMode       = modeQ;
	assign driverType    = typeQ[15:0];
	assign edgeRate      = slewQ[15:0];
	assign pullSelect    = pullQ;
	assign padAnalog     = analog_q;
	assign padDigitalOut = digOut_q;
	assign padAltFunc    = altFunc_q;
	assign padOpenDrain  = openDrain_q;
	assign padPullUp     = pullUp_q;
	assign padPullDown   = pullDown_q;

	assign rdMode  = addrIs(bus.rdAddr, `GPCFG_OFS_MODE);
	assign rdType  = addrIs(bus.rdAddr, `GPCFG_OFS_TYPE);
	assign rdSlew  = addrIs(bus.rdAddr, `GPCFG_OFS_SLEW);
	assign rdPull  = addrIs(bus.rdAddr, `GPCFG_OFS_PULL);
	assign rdLevel = addrIs(bus.rdAddr, `GPCFG_OFS_LEVEL);

	// input levels read back in the low half
	assign rdWord = rdMode ? modeQ :
		rdType ? typeQ :
		rdSlew ? slewQ :
		rdPull ? pullQ :
		rdLevel ? {16'h0000, levelQ} : 32'h00000000;
	assign bus.rdData = rdWord;
	assign bus.rdHit  = rdMode || rdType || rdSlew || rdPull || rdLevel;

	a_mode_reset: assert property (@(posedge clock)
		reset |=> modeQ == RST_MODE && padAnalog == fieldIs(RST_MODE, 2'h3))
		else $error("Mode register missed its reset value.");

	a_pull_reset: assert property (@(posedge clock)
		reset |=> pullQ == RST_PULL && padPullUp == fieldIs(RST_PULL, 2'h1))
		else $error("Pull register missed its reset value.");

	a_slew_reset: assert property (@(posedge clock)
		reset |=> edgeRate == RST_SLEW[15:0])
		else $error("Slew register missed its reset value.");

	a_type_clear: assert property (@(posedge clock)
		reset |=> typeQ == 32'h00000000 && levelQ == 16'h0000)
		else $error("Type or input data not cleared by reset.");

	a_input_sync: assert property (@(posedge clock)
		(!reset)[*3] |-> levelQ == ($past(padIn, 2) & PIN_MASK))
		else $error("Input level does not follow pad two cycles late.");

	a_level_readonly: assert property (@(posedge clock) disable iff (reset)
		levelWr |=> $stable(modeQ) && $stable(typeQ) && $stable(slewQ) && $stable(pullQ))
		else $error("Write to input data changed a register.");

	a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
		(rdType || rdSlew || rdLevel) |-> rdWord[31:16] == 16'h0000)
		else $error("Reserved half of a register reads nonzero.");

	a_unimpl_zero: assert property (@(posedge clock)
		(modeQ & ~FIELD_MASK) == 32'h0 && (pullQ & ~FIELD_MASK) == 32'h0 &&
		(slewQ & ~BIT_MASK) == 32'h0 && (levelQ & ~PIN_MASK) == 16'h0)
		else $error("Unimplemented pin field is nonzero.");

	a_mode_write: assert property (@(posedge clock) disable iff (reset)
		modeWr && bus.wrStrb == 4'hF |=> modeQ == ($past(bus.wrData) & FIELD_MASK)
		##0 padAltFunc == fieldIs(modeQ, 2'h2))
		else $error("Mode write did not land.");

	a_type_write: assert property (@(posedge clock) disable iff (reset)
		typeWr && bus.wrStrb == 4'hF |=> typeQ == ($past(bus.wrData) & BIT_MASK)
		&& padOpenDrain == (typeQ[15:0] & padDigitalOut))
		else $error("Type write or open-drain decode wrong.");

	a_slew_write: assert property (@(posedge clock) disable iff (reset)
		slewWr && bus.wrStrb[1:0] == 2'h3 |=> edgeRate == ($past(bus.wrData[15:0]) & PIN_MASK))
		else $error("Slew write did not reach the pads.");

	a_pull_decode: assert property (@(posedge clock) disable iff (reset)
		(padPullUp & padPullDown) == 16'h0000 && padPullUp == fieldIs(pullQ, 2'h1))
		else $error("Pull decode wrong.");
endmodule

// ===== test/gpcfg_pad_model.sv
`timescale 1ns/10ps

module gpcfg_pad_model (
	// Clock.
	input  wire logic        clock,
	// Bench stimulus.
	input  wire logic [15:0] extDrive,
	input  wire logic [15:0] extLevel,
	// Pull resistors from the port.
	input  wire logic [15:0] pullUp,
	input  wire logic [15:0] pullDown,
	// Pin levels.
	output logic      [15:0] padLevel
);
	logic floatQ = 1'b0;

	// A floating pin with no pull wanders, so it toggles every cycle.
	always_ff @(posedge clock)
	begin
		floatQ <= ~floatQ;
	end

	assign padLevel = (extDrive & extLevel) | (~extDrive & pullUp)
		| (~extDrive & ~pullUp & ~pullDown & {16{floatQ}});
endmodule

// ===== test/testbench.sv
`timescale 1ns/10ps
`include "gpcfg_map.svh"

module testbench;
	typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} gpcfg_exp_t;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  awAddr = 8'h00;
	logic [7:0]  arAddr = 8'h00;
	logic        awValid = 1'b0;
	logic        wValid = 1'b0;
	logic        bReady = 1'b0;
	logic        arValid = 1'b0;
	logic        rReady = 1'b0;
	logic [31:0] wData = 32'h00000000;
	logic [3:0]  wStrb = 4'h0;
	logic [15:0] extDrive = 16'h0000;
	logic [15:0] extLevel = 16'h0000;
	logic        awReady, wReady, bValid, arReady, rValid;
	logic [1:0]  bResp, rResp;
	logic [31:0] rData, pinMode, pullSelect, modeE, typeE, slewE, pullE;
	logic [15:0] padIn, driverType, edgeRate, padAnalog, padDigitalOut, padAltFunc;
	logic [15:0] padOpenDrain, padPullUp, padPullDown, anE, dgE, alE, puE, pdE;
	logic [31:0] pinModeB, pullSelectB;
	logic [15:0] driverTypeB, edgeRateB;
	logic [31:0] lfsr = 32'h614A30C8;
	gpcfg_exp_t  rdQ[$];
	gpcfg_exp_t  monE;
	logic [1:0]  bQ[$];
	int          n_errors = 0;
	int          compares = 0;
	int          cycles = 0;

	always #25 clock = ~clock;

	gpcfg_port dut (
		.clock(clock), .reset(reset),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.padIn(padIn), .pinMode(pinMode), .driverType(driverType), .edgeRate(edgeRate),
		.pullSelect(pullSelect), .padAnalog(padAnalog), .padDigitalOut(padDigitalOut),
		.padAltFunc(padAltFunc), .padOpenDrain(padOpenDrain), .padPullUp(padPullUp),
		.padPullDown(padPullDown)
	);

	gpcfg_pad_model pads (
		.clock(clock), .extDrive(extDrive), .extLevel(extLevel),
		.pullUp(padPullUp), .pullDown(padPullDown), .padLevel(padIn)
	);

	gpcfg_port #(.PIN_COUNT(2)) dutB (
		.clock(clock), .reset(reset),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(),
		.s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rReady),
		.padIn(padIn), .pinMode(pinModeB), .driverType(driverTypeB), .edgeRate(edgeRateB),
		.pullSelect(pullSelectB), .padAnalog(), .padDigitalOut(), .padAltFunc(),
		.padOpenDrain(), .padPullUp(), .padPullDown()
	);

	task give_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		compares++;
		if ((got & mask) !== (exp & mask))
		begin
			n_errors++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t response got %h exp %h", $time, got, exp);
		end
	endtask

	// Checks each answer against the oldest note.
	always @(posedge clock)
	begin
		if (rValid && rReady)
		begin
			monE = rdQ.pop_front();
			cmp_word(rData, monE.data, monE.mask);
			cmp_resp(rResp, monE.resp);
		end
		if (bValid && bReady)
			cmp_resp(bResp, bQ.pop_front());
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] resp);
		logic awT, wT, bT;
		bQ.push_back(resp);
		awAddr <= a;
		wData <= d;
		wStrb <= s;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		bT = 1'b0;
		while (!bT)
		begin
			@(negedge clock);
			awT = awValid && awReady;
			wT = wValid && wReady;
			bT = bValid;
			@(posedge clock);
			if (awT)
				awValid <= 1'b0;
			if (wT)
				wValid <= 1'b0;
		end
	endtask

	task axi_read(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] resp);
		logic arT, rT;
		rdQ.push_back('{d, m, resp});
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		rT = 1'b0;
		while (!rT)
		begin
			@(negedge clock);
			arT = arValid && arReady;
			rT = rValid;
			@(posedge clock);
			if (arT)
				arValid <= 1'b0;
		end
	endtask

	// Byte lanes merge into the expected copy; reserved bits stay zero.
	task wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] bm;
		if (a == 8'h0C)
			d = d & ~((d & (d >> 1) & 32'h55555555) << 1);
		else if (a == 8'h04 || a == 8'h08)
			d = d & 32'h0000FFFF;
		bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		case (a)
			8'h00: modeE = (modeE & ~bm) | (d & bm);
			8'h04: typeE = ((typeE & ~bm) | (d & bm)) & 32'h0000FFFF;
			8'h08: slewE = ((slewE & ~bm) | (d & bm)) & 32'h0000FFFF;
			default: pullE = (pullE & ~bm) | (d & bm);
		endcase
		axi_write(a, d, s, `GPCFG_RESP_OKAY);
	endtask

	task rd_reg(input logic [7:0] a);
		axi_read(a, a == 8'h00 ? modeE : a == 8'h04 ? typeE : a == 8'h08 ? slewE : pullE,
			32'hFFFFFFFF, `GPCFG_RESP_OKAY);
	endtask

	task chk_pads;
		for (int y = 0; y < 16; y++)
		begin
			anE[y] = modeE[2*y+:2] == 2'h3;
			dgE[y] = modeE[2*y+:2] == 2'h1 || modeE[2*y+:2] == 2'h2;
			alE[y] = modeE[2*y+:2] == 2'h2;
			puE[y] = pullE[2*y+:2] == 2'h1;
			pdE[y] = pullE[2*y+:2] == 2'h2;
		end
		@(negedge clock);
		cmp_word(pinMode, modeE, 32'hFFFFFFFF);
		cmp_word(32'(driverType), typeE, 32'hFFFFFFFF);
		cmp_word(32'(edgeRate), slewE, 32'hFFFFFFFF);
		cmp_word(pullSelect, pullE, 32'hFFFFFFFF);
		cmp_word(32'(padAnalog), 32'(anE), 32'hFFFFFFFF);
		cmp_word({padDigitalOut, padAltFunc}, {dgE, alE}, 32'hFFFFFFFF);
		cmp_word(pinModeB, modeE & 32'h0000000F, 32'hFFFFFFFF);
		cmp_word(pullSelectB, pullE & 32'h0000000F, 32'hFFFFFFFF);
		cmp_word({edgeRateB, driverTypeB}, {slewE[15:0], typeE[15:0]} & 32'h00030003,
			32'hFFFFFFFF);
		cmp_word(32'(padOpenDrain), 32'(typeE[15:0] & dgE), 32'hFFFFFFFF);
		cmp_word({padPullUp, padPullDown}, {puE, pdE}, 32'hFFFFFFFF);
		@(posedge clock);
	endtask

	initial
	begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		modeE = `GPCFG_RST_MODE;
		typeE = `GPCFG_RST_TYPE;
		slewE = `GPCFG_RST_SLEW;
		pullE = `GPCFG_RST_PULL;
		@(posedge clock);
		chk_pads();
		for (int a = 0; a < 16; a += 4)
			rd_reg(8'(a));
		axi_read(8'h14, 32'h00000000, 32'hFFFFFFFF, `GPCFG_RESP_SLVERR);
		for (int m = 0; m < 4; m++)
		begin
			wr_reg(8'h00, {16{m[1:0]}}, 4'hF);
			wr_reg(8'h0C, {16{m[1:0]}}, 4'hF);
			rd_reg(8'h00);
			chk_pads();
		end
		repeat (16)
		begin
			lfsr = next_rand(lfsr);
			wr_reg({4'h0, lfsr[9:8], 2'h0}, lfsr ^ 32'hA5C3E187, lfsr[7:4]);
			rd_reg({4'h0, lfsr[9:8], 2'h0});
			chk_pads();
		end
		axi_write(8'h10, 32'h0000FFFF, 4'hF, `GPCFG_RESP_OKAY);
		axi_write(8'h14, 32'hFFFFFFFF, 4'hF, `GPCFG_RESP_SLVERR);
		for (int a = 0; a < 16; a += 4)
			rd_reg(8'(a));
		wr_reg(8'h0C, 32'h6A5A1259, 4'hF);
		chk_pads();
		repeat (8)
		begin
			lfsr = next_rand(lfsr);
			extDrive <= lfsr[15:0];
			extLevel <= lfsr[31:16];
			repeat (3) @(posedge clock);
			axi_read(8'h10, 32'((lfsr[15:0] & lfsr[31:16]) | (~lfsr[15:0] & puE)),
				32'h0000FFFF & 32'(lfsr[15:0] | puE | pdE), `GPCFG_RESP_OKAY);
			axi_read(8'h10, 32'h00000000, 32'hFFFF0000, `GPCFG_RESP_OKAY);
		end
		repeat (2) @(posedge clock);
		cmp_word(32'(rdQ.size() + bQ.size()), 32'h00000000, 32'hFFFFFFFF);
		give_verdict();
	end
endmodule
